// File: inc/dpram_host_params.svh
// Constants for the dual-port memory port controller: timing counts and register map.
`ifndef DPRAM_HOST_PARAMS_SVH
`define DPRAM_HOST_PARAMS_SVH
`define CLK_PERIOD_NS      50
`define ARB_TIME_NS        45
`define ARB_CYCLES         ((`ARB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_HOLD_NS      30
`define WRITE_HOLD_CYCLES  ((`WRITE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_VALID_NS      40
`define READ_VALID_CYCLES  ((`READ_VALID_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REG_ADDR_OFS       4'h0
`define REG_WDATA_OFS      4'h1
`define REG_CMD_OFS        4'h2
`define REG_STATUS_OFS     4'h3
`define REG_RDATA_OFS      4'h4
`define REG_EVENTS_OFS     4'h5
`define CMD_GO_BIT         0
`define CMD_WRITE_BIT      1
`define CMD_LB_BIT         2
`define CMD_UB_BIT         3
`endif

// File: inc/dpram_host_pkg.sv
// Types shared by the memory port controller.
package dpram_host_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_WAIT  = 3'b010,
		ST_WRITE = 3'b011,
		ST_READ  = 3'b100,
		ST_DONE  = 3'b101
	} port_state_t;
endpackage : dpram_host_pkg

// File: rtl/pin_sync.sv
// Two-flop synchroniser for asynchronous pin inputs.
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,  // System clock
	input  wire logic             resetn, // Asynchronous reset
	input  wire logic [WIDTH-1:0] async_in, // Raw pin level
	output logic      [WIDTH-1:0] sync_out  // Synchronised level
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_state_t;
	sync_state_t st_r;
	sync_state_t st_nxt;
	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync: WIDTH must be at least 1.");
	end
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign sync_out = st_r.s2;
endmodule : pin_sync

// File: rtl/dpram_port_host.sv
// Controller that drives one port of the dual-port memory from a register interface.
//
// Functional notes
// RULE1: Deasserted select puts the port in standby with data pins floating.
// RULE2: Any location can be read or written while select is low.
// RULE3: Arbiter lets one access proceed and flags the other port.
// RULE4: A write from a flagged port is blocked inside the memory.
// RULE5: Write-inhibit input variant: high permits, low blocks writes.
// RULE6: Arbitrating variant flag is open drain and needs a pull-up.
// RULE7: One arbitrating part feeds inhibit inputs of all others.
// RULE8: Controller delays write strobe by maximum arbitration time.
// RULE9: Controller holds write strobe a hold time after flag returns high.
// RULE10: Both strobes low writes both bytes regardless of output enable.
// RULE11: One strobe low writes that byte; other lane reads if enabled.
// RULE12: Both strobes high read with output enable low, else float.
// RULE13: Read data invalid while flag low and until delay after release.
// RULE14: Contention only on both selects low and matching addresses.
// RULE15: Violated setup still flags exactly one port, never both.
// RULE16: Writes ignored while own flag is driven low.
// RULE17: Flags may be ORed into an illegal-access interrupt.
// RULE18: A write happens only while select and strobe are both low.
// RULE19: Controller holds strobe or select high during address changes.
// RULE20: Address comparison covers all eleven address bits.
`timescale 1ns/1ns
`include "dpram_host_params.svh"
module dpram_port_host
	import dpram_host_pkg::*;
#(
	parameter int ADDR_W = 11,
	parameter int DATA_W = 16
) (
	input  wire logic              clock,               // 20 MHz system clock
	input  wire logic              resetn,              // Asynchronous reset, active low
	input  wire logic [3:0]        reg_addr,            // Register address
	input  wire logic [31:0]       reg_wdata,           // Register write data
	input  wire logic              reg_write,           // Register write strobe
	input  wire logic              reg_read,            // Register read strobe
	output logic      [31:0]       reg_rdata,           // Read data, cycle after strobe
	output logic                   port_select_n,       // Memory port select
	output logic                   output_enable_n,     // Memory output enable
	output logic                   lower_byte_write_n,  // Lower byte write strobe
	output logic                   upper_byte_write_n,  // Upper byte write strobe
	output logic      [ADDR_W-1:0] port_address,        // Memory port address
	output logic      [DATA_W-1:0] data_out,            // Data toward memory
	output logic      [DATA_W-1:0] data_oe_n,           // Data drive enable, low drives
	input  wire logic [DATA_W-1:0] data_in,             // Data pin level
	input  wire logic              contention_flag_n,   // Contention flag from arbiter
	output logic                   contention_seen      // Sticky contention event level
);
	localparam int ARB_CYC  = `ARB_CYCLES;
	localparam int HOLD_CYC = `WRITE_HOLD_CYCLES;
	localparam int RDV_CYC  = `READ_VALID_CYCLES;
	localparam int CNT_W    = 4;
	// The lane enables are built from two 8-bit halves, so only these sizes are served.
	if (ADDR_W != 11 || DATA_W != 16) begin : g_bad_size
		$error("dpram_port_host: only 11 address and 16 data bits are served.");
	end
	if (ARB_CYC + 1 >= 16 || HOLD_CYC >= 16 || RDV_CYC + 2 >= 16) begin : g_bad_timing
		$error("dpram_port_host: timing counts exceed counter width.");
	end

	typedef struct packed {
		port_state_t       state;
		logic [CNT_W-1:0]  cnt;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic              is_write;
		logic              lb;
		logic              ub;
		logic              busy;
		logic              done;
		logic              contention;
		logic [31:0]       rd;
		logic              sel_n;
		logic              oe_n;
		logic              lbw_n;
		logic              ubw_n;
		logic [DATA_W-1:0] doe_n;
	} host_state_t;

	host_state_t st_r;
	host_state_t st_nxt;
	logic        flag_s;
	logic        flag_hit_s;
	logic [DATA_W-1:0] din_s;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	pin_sync #(.WIDTH(DATA_W + 1)) u_sync (
		.clock    (clock),
		.resetn   (resetn),
		.async_in ({~contention_flag_n, data_in}), // RULE7
		.sync_out ({flag_hit_s, din_s})
	);
	// The flag travels inverted so the synchroniser's reset value reads as no contention.
	assign flag_s = ~flag_hit_s;

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n);
	endfunction : cyc

	// ------------------------------------------------------------
	// Access sequencer
	// ------------------------------------------------------------
	always_comb begin
		st_nxt    = st_r;
		st_nxt.rd = 32'h00000000;
		if (reg_read) begin
			case (reg_addr)
				`REG_ADDR_OFS:   st_nxt.rd = 32'(st_r.addr);
				`REG_WDATA_OFS:  st_nxt.rd = 32'(st_r.wdata);
				`REG_STATUS_OFS: st_nxt.rd = {29'h0, st_r.contention, st_r.done, st_r.busy};
				`REG_RDATA_OFS:  st_nxt.rd = 32'(st_r.rdata);
				`REG_EVENTS_OFS: st_nxt.rd = {31'h0, flag_s};
				default:         st_nxt.rd = 32'h00000000;
			endcase
		end
		if (reg_write) begin
			case (reg_addr)
				`REG_ADDR_OFS:  if (!st_r.busy) st_nxt.addr = reg_wdata[ADDR_W-1:0];
				`REG_WDATA_OFS: if (!st_r.busy) st_nxt.wdata = reg_wdata[DATA_W-1:0];
				`REG_CMD_OFS: begin
					if (reg_wdata[`CMD_GO_BIT] && !st_r.busy) begin
						st_nxt.is_write = reg_wdata[`CMD_WRITE_BIT];
						st_nxt.lb       = reg_wdata[`CMD_LB_BIT];
						st_nxt.ub       = reg_wdata[`CMD_UB_BIT];
						st_nxt.busy     = 1'b1;
						st_nxt.done     = 1'b0;
						st_nxt.state    = ST_SETUP;
					end
				end
				`REG_STATUS_OFS: begin
					if (reg_wdata[1]) st_nxt.done = 1'b0;
					if (reg_wdata[2]) st_nxt.contention = 1'b0;
				end
				default: ;
			endcase
		end
		// Contention sets after the clear so an event in the same cycle is kept.
		if (!flag_s && !st_r.sel_n) st_nxt.contention = 1'b1; // RULE17
		case (st_r.state)
			ST_IDLE: begin
				st_nxt.sel_n = 1'b1; // RULE1
				st_nxt.oe_n  = 1'b1;
				st_nxt.lbw_n = 1'b1;
				st_nxt.ubw_n = 1'b1;
				st_nxt.doe_n = '1;
			end
			ST_SETUP: begin
				// Address is already stable; strobes stay high across its change.
				st_nxt.sel_n = 1'b0; // RULE19
				st_nxt.oe_n  = st_r.is_write;
				// The flag reaches this logic two flops late, so one extra cycle covers it.
				st_nxt.cnt   = cyc(ARB_CYC + 1);
				st_nxt.state = ST_WAIT;
			end
			ST_WAIT: begin
				// Waiting out arbitration keeps a contended write from ever starting.
				if (st_r.cnt != '0) begin
					st_nxt.cnt = st_r.cnt - 1'b1; // RULE8
				end else if (flag_s) begin
					if (st_r.is_write) begin
						st_nxt.lbw_n = ~st_r.lb; // RULE10 RULE11
						st_nxt.ubw_n = ~st_r.ub; // RULE18
						st_nxt.doe_n = {{8{~st_r.ub}}, {8{~st_r.lb}}};
						st_nxt.cnt   = cyc(HOLD_CYC);
						st_nxt.state = ST_WRITE;
					end else begin
						st_nxt.cnt   = cyc(RDV_CYC + 2);
						st_nxt.state = ST_READ;
					end
				end
			end
			ST_WRITE: begin
				// A flag mid-write restarts the hold so the write ends after release.
				if (!flag_s) st_nxt.cnt = cyc(HOLD_CYC); // RULE9
				else if (st_r.cnt != '0) st_nxt.cnt = st_r.cnt - 1'b1;
				else begin
					st_nxt.lbw_n = 1'b1;
					st_nxt.ubw_n = 1'b1;
					st_nxt.state = ST_DONE;
				end
			end
			ST_READ: begin
				// Data are trusted only after the flag stays high for the valid delay.
				if (!flag_s) st_nxt.cnt = cyc(RDV_CYC + 2); // RULE13
				else if (st_r.cnt != '0) st_nxt.cnt = st_r.cnt - 1'b1;
				else begin
					st_nxt.rdata = din_s; // RULE12
					st_nxt.state = ST_DONE;
				end
			end
			ST_DONE: begin
				st_nxt.sel_n = 1'b1;
				st_nxt.oe_n  = 1'b1;
				st_nxt.doe_n = '1;
				st_nxt.busy  = 1'b0;
				st_nxt.done  = 1'b1;
				st_nxt.state = ST_IDLE;
			end
			default: st_nxt.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_r       <= '0;
			st_r.state <= ST_IDLE;
			st_r.sel_n <= 1'b1;
			st_r.oe_n  <= 1'b1;
			st_r.lbw_n <= 1'b1;
			st_r.ubw_n <= 1'b1;
			st_r.doe_n <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata          = st_r.rd;
	assign port_select_n      = st_r.sel_n;
	assign output_enable_n    = st_r.oe_n;
	assign lower_byte_write_n = st_r.lbw_n;
	assign upper_byte_write_n = st_r.ubw_n;
	assign port_address       = st_r.addr;
	assign data_out           = st_r.wdata;
	assign data_oe_n          = st_r.doe_n;
	assign contention_seen    = st_r.contention;
endmodule : dpram_port_host

// File: tb/dpram_port_host_asserts.sv
// Pin-level checks on the memory port controller.
`timescale 1ns/1ns
module dpram_port_host_asserts (
	input wire logic        clock,              // Clock
	input wire logic        resetn,             // Reset
	input wire logic        port_select_n,      // Select
	input wire logic        output_enable_n,    // Output enable
	input wire logic        lower_byte_write_n, // Lower strobe
	input wire logic        upper_byte_write_n, // Upper strobe
	input wire logic [10:0] port_address,       // Address
	input wire logic [15:0] data_oe_n,          // Drive enables
	input wire logic        contention_flag_n,  // Flag pin
	input wire logic        contention_seen     // Sticky event
);
	wire no_wr = lower_byte_write_n && upper_byte_write_n;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	a_strobe_in_sel: assert property (!no_wr |-> !port_select_n)
		else $error("strobe outside select");
	a_addr_quiet: assert property ($changed(port_address) |-> port_select_n || no_wr)
		else $error("address moved during write");
	a_arb_delay: assert property ($fell(port_select_n) |-> no_wr [*2])
		else $error("strobe before arbitration time");
	a_flag_gate: assert property (!$stable(no_wr) && !no_wr |-> $past(contention_flag_n, 3))
		else $error("strobe started under contention");
	a_hold_after: assert property ($rose(no_wr) |-> $past(contention_flag_n, 3)
		&& $past(contention_flag_n, 4)) else $error("write hold too short");
	a_idle_float: assert property (port_select_n |-> output_enable_n && no_wr
		&& data_oe_n == 16'hFFFF) else $error("pins active in standby");
	a_read_no_drive: assert property (!output_enable_n |-> no_wr && data_oe_n == 16'hFFFF)
		else $error("drive during read");
	a_lane_drive: assert property ((lower_byte_write_n || data_oe_n[7:0] == 8'h00)
		&& (upper_byte_write_n || data_oe_n[15:8] == 8'h00)) else $error("lane not driven");
	c_write: cover property ($fell(lower_byte_write_n));
	c_read: cover property ($fell(output_enable_n));
	c_contend: cover property ($rose(contention_seen));
endmodule : dpram_port_host_asserts
bind dpram_port_host dpram_port_host_asserts chk_u (.clock, .resetn, .port_select_n,
	.output_enable_n, .lower_byte_write_n, .upper_byte_write_n, .port_address,
	.data_oe_n, .contention_flag_n, .contention_seen);

// File: tb/dpram_port_model.sv
// Behavioural memory port with a contention flag driven from the contend input.
`timescale 1ns/1ns
module dpram_port_model (
	input  wire logic        clock,              // Clock
	input  wire logic        port_select_n,      // Select
	input  wire logic        output_enable_n,    // Output enable
	input  wire logic        lower_byte_write_n, // Lower strobe
	input  wire logic        upper_byte_write_n, // Upper strobe
	input  wire logic [10:0] port_address,       // Address
	input  wire logic [15:0] data_out,           // Controller data
	input  wire logic [15:0] data_oe_n,          // Low drives
	input  wire logic        contend,            // Other port wins
	output logic      [15:0] data_in,            // Pin level
	output logic             contention_flag_n   // Flag pin
);
	logic [15:0] mem [0:2047];
	logic [15:0] rd;
	logic        tgl = 1'b0;
	logic        lo_rd, hi_rd;
	// The flag is driven low while contend is high and driven high otherwise; no pull-up is modelled.
	assign contention_flag_n = contend ? 1'b0 : 1'b1;
	// Garbage while flagged, so a controller reading too early is caught.
	assign rd = contention_flag_n ? mem[port_address] : ~mem[port_address];
	assign lo_rd = !port_select_n && !output_enable_n && lower_byte_write_n;
	assign hi_rd = !port_select_n && !output_enable_n && upper_byte_write_n;
	always_ff @(posedge clock) begin
		tgl <= ~tgl;
		if (!port_select_n && contention_flag_n) begin
			if (!lower_byte_write_n)
				mem[port_address][7:0] <= data_in[7:0];
			if (!upper_byte_write_n)
				mem[port_address][15:8] <= data_in[15:8];
		end
	end
	always_comb begin
		for (int i = 0; i < 16; i++)
			data_in[i] = !data_oe_n[i] ? data_out[i] : ((i < 8 ? lo_rd : hi_rd) ? rd[i] : tgl);
	end
endmodule : dpram_port_model

// File: tb/testbench.sv
// Self-checking bench for the memory port controller.
`timescale 1ns/1ns
module testbench;
	logic        clock, resetn, reg_write, reg_read, contend, contention_flag_n, contention_seen;
	logic        port_select_n, output_enable_n, lower_byte_write_n, upper_byte_write_n;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [10:0] port_address;
	logic [15:0] data_out, data_oe_n, data_in;
	int          mismatches = 0;
	int          checks = 0;
	dpram_port_host dut_u (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .port_select_n, .output_enable_n, .lower_byte_write_n, .upper_byte_write_n,
		.port_address, .data_out, .data_oe_n, .data_in, .contention_flag_n, .contention_seen);
	dpram_port_model mem_u (.clock, .port_select_n, .output_enable_n, .lower_byte_write_n,
		.upper_byte_write_n, .port_address, .data_out, .data_oe_n, .contend, .data_in,
		.contention_flag_n);
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// A gap cycle keeps back-to-back writes from lowering and raising the strobe at once.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(posedge clock);
		rv = reg_rdata;
	endtask : rd
	task automatic wait_done();
		int n;
		n = 0;
		rv = 32'h0;
		while (rv[1] !== 1'b1 && n < 60) begin
			rd(4'h3);
			n++;
		end
		if (rv[1] !== 1'b1) begin
			mismatches++;
			give_verdict();
		end else begin
			wr(4'h3, 32'h6);
		end
	endtask : wait_done
	task automatic access(input logic [10:0] a, input logic [15:0] d, input logic [3:0] c);
		wr(4'h0, {21'h0, a});
		wr(4'h1, {16'h0, d});
		wr(4'h2, {28'h0, c});
		wait_done();
	endtask : access
	task automatic wr_rd(input logic [10:0] a, input logic [15:0] d, input logic [3:0] c,
		input logic [15:0] e);
		access(a, d, c);
		access(a, 16'h0, 4'h1);
		rd(4'h4);
		check(rv, {16'h0, e});
	endtask : wr_rd
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		resetn = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		contend = 1'b0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		check({port_select_n, output_enable_n, data_oe_n}, 32'h3FFFF);
		wr_rd(11'h7FF, 16'hA55A, 4'hF, 16'hA55A);
		wr_rd(11'h7FF, 16'h1234, 4'h7, 16'hA534);
		wr_rd(11'h7FF, 16'hCD00, 4'hB, 16'hCD34);
		wr_rd(11'h000, 16'h0F0F, 4'hF, 16'h0F0F);
		wr_rd(11'h7FF, 16'h0000, 4'h1, 16'hCD34);
		contend <= 1'b1;
		wr(4'h0, 32'h7FF);
		wr(4'h1, 32'hFFFF);
		wr(4'h2, 32'hF);
		repeat (12) @(posedge clock);
		rd(4'h3);
		check(rv, 32'h5);
		check(contention_seen, 1'b1);
		rd(4'h5);
		check(rv, 32'h0);
		contend <= 1'b0;
		wait_done();
		contend <= 1'b1;
		wr(4'h2, 32'h1);
		repeat (12) @(posedge clock);
		contend <= 1'b0;
		wait_done();
		rd(4'h4);
		check(rv, 32'hFFFF);
		rd(4'hF);
		check(rv, 32'h0);
		give_verdict();
	end
endmodule : testbench
